// ===== design/usbc_sender_ctrl.v
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`include "usbc_defines.vh"

// Contract
// - Hang up after thirty seconds of continuous carrier absence.
// - Compare received identification bit by bit; start only on full match.
// - Send no tape data before a valid identification is recognized.
// - Identification is 14 bits; valid one switches the reader on.
// - Stop sending whenever circuit continuity is lost.
// - On break: stop reader, light break lamp, ring bell.
// - Break acts only in operate position, never in test.
// - Break-equipped sender works only with break-equipped receivers.
module usbc_sender_ctrl
#(
   parameter [63:0] CARR_CYC = `USBC_CARR_CYC,
   parameter        ID_BITS  = `USBC_ID_BITS,
   parameter [13:0] ID_CODE  = `USBC_ID_CODE
)
(
   // Clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   // Wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [3:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // Data set
   input  wire        ring_i,
   input  wire        carrier_i,
   input  wire        rev_chan_i,
   input  wire        id_bit_i,
   input  wire        id_strobe_i,
   output reg         off_hook_o,
   // Reader and alarms
   input  wire        tape_i,
   output reg         tx_data_o,
   output reg         reader_on_o,
   output reg         break_lamp_o,
   output reg         bell_o,
   output reg         irq_o
);

   // ==========================================
   // States
   localparam [3:0] S_IDLE = 4'h1;
   localparam [3:0] S_WAIT = 4'h2;
   localparam [3:0] S_SEND = 4'h4;
   localparam [3:0] S_BRK  = 4'h8;

   reg  [3:0]  state_reg;
   reg  [3:0]  ctrl_reg;
   reg  [4:0]  irq_reg;
   reg  [4:0]  mask_reg;
   reg  [63:0] carr_cnt_reg;
   reg  [13:0] id_shift_reg;
   reg  [4:0]  id_cnt_reg;
   reg  [4:0]  ev_next;
   reg  [3:0]  state_next;

   wire        wb_req;
   wire        wb_wr;
   wire        carr_timeout;
   wire        id_done;
   wire        id_match;
   wire        brk_ev;
   wire        wr_ctrl;
   wire        wr_irq;
   wire        wr_mask;
   wire        lamp_clr;
   wire        send_go;
   wire        brk_enter;
   wire [4:0]  irq_next;
   wire [4:0]  mask_next;

   function sel_hit;
      input [3:0] adr;
      input [3:0] ofs;
      begin
         sel_hit = (adr == ofs);
      end
   endfunction

   // ==========================================
   // Bus access
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0];

   // ==========================================
   // Event detection
   // Timer only runs off-hook; restarts on any carrier return
   assign carr_timeout = off_hook_o & ~carrier_i
                         & (carr_cnt_reg >= CARR_CYC - 64'h1);
   assign id_done  = id_strobe_i & (id_cnt_reg == ID_BITS - 1);
   assign id_match = ({id_shift_reg[12:0], id_bit_i} == ID_CODE);
   // Break only honoured in operate; needs a break-equipped far end
   assign brk_ev   = rev_chan_i & ctrl_reg[`USBC_CTRL_OPERATE]
                     & (state_reg == S_SEND);

   always @*
   begin
      ev_next    = 5'h00;
      state_next = state_reg;
      case (state_reg)
         S_IDLE:
         begin
            if (ring_i & ctrl_reg[`USBC_CTRL_ENABLE]
                & ctrl_reg[`USBC_CTRL_ANSWER])
               state_next = S_WAIT;
         end
         S_WAIT:
         begin
            if (carr_timeout)
            begin
               state_next = S_IDLE;
               ev_next[`USBC_EV_HANGUP] = 1'b1;
            end
            else if (id_done & id_match)
            begin
               state_next = S_SEND;
               ev_next[`USBC_EV_ID_OK] = 1'b1;
            end
            else if (id_done)
               ev_next[`USBC_EV_ID_BAD] = 1'b1;
         end
         S_SEND:
         begin
            if (carr_timeout)
            begin
               state_next = S_IDLE;
               ev_next[`USBC_EV_HANGUP] = 1'b1;
            end
            else if (brk_ev)
            begin
               state_next = S_BRK;
               ev_next[`USBC_EV_BREAK] = 1'b1;
            end
            else if (~carrier_i & carr_cnt_reg == 64'h0)
               ev_next[`USBC_EV_CARR_LOST] = 1'b1;
         end
         S_BRK:
         begin
            if (carr_timeout)
            begin
               state_next = S_IDLE;
               ev_next[`USBC_EV_HANGUP] = 1'b1;
            end
         end
         default:
            state_next = S_IDLE;
      endcase
   end

   // ==========================================
   // Register decode
   assign wr_ctrl   = wb_wr & sel_hit(wb_adr_i, `USBC_CTRL_OFS);
   assign wr_irq    = wb_wr & sel_hit(wb_adr_i, `USBC_IRQ_OFS);
   assign wr_mask   = wb_wr & sel_hit(wb_adr_i, `USBC_MASK_OFS);
   assign lamp_clr  = wr_ctrl & wb_dat_i[`USBC_CTRL_LAMPCLR];
   // Set wins over a write-one clear in the same cycle
   assign irq_next  = (irq_reg & ~(wr_irq ? wb_dat_i[4:0] : 5'h00))
                      | ev_next;
   assign mask_next = wr_mask ? wb_dat_i[4:0] : mask_reg;
   assign send_go   = (state_next == S_SEND) & carrier_i;
   assign brk_enter = (state_next == S_BRK) & (state_reg != S_BRK);

   // ==========================================
   // Bus slave
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         ctrl_reg <= 4'h0;
         mask_reg <= 5'h00;
      end
      else if (ce_i)
      begin
         // Registered ack costs one wait state but keeps paths short
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h00000000;
         if (wb_req & ~wb_we_i)
         begin
            if (sel_hit(wb_adr_i, `USBC_CTRL_OFS))
               wb_dat_o <= {28'h0000000, ctrl_reg};
            else if (sel_hit(wb_adr_i, `USBC_STAT_OFS))
               wb_dat_o <= {24'h000000, state_reg, break_lamp_o,
                            reader_on_o, off_hook_o, carrier_i};
            else if (sel_hit(wb_adr_i, `USBC_IRQ_OFS))
               wb_dat_o <= {27'h0000000, irq_reg};
            else if (sel_hit(wb_adr_i, `USBC_MASK_OFS))
               wb_dat_o <= {27'h0000000, mask_reg};
         end
         if (wr_ctrl)
            ctrl_reg <= {1'b0, wb_dat_i[2:0]};
         mask_reg <= mask_next;
      end
   end

   // ==========================================
   // Call state
   always @(posedge clk_i)
   begin
      if (rst_i)
         state_reg <= S_IDLE;
      else if (ce_i)
         state_reg <= state_next;
   end

   // ==========================================
   // Interrupts
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_reg <= 5'h00;
         irq_o   <= 1'b0;
      end
      else if (ce_i)
      begin
         irq_reg <= irq_next;
         // Built from next values so the level never lags a write
         irq_o   <= |(irq_next & mask_next);
      end
   end

   // ==========================================
   // Carrier absence timer
   // Wide counter so the full hang-up span fits at the system clock
   always @(posedge clk_i)
   begin
      if (rst_i)
         carr_cnt_reg <= 64'h0;
      else if (ce_i)
      begin
         if (carrier_i | ~off_hook_o | carr_timeout)
            carr_cnt_reg <= 64'h0;
         else
            carr_cnt_reg <= carr_cnt_reg + 64'h1;
      end
   end

   // ==========================================
   // Identification receiver
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         id_cnt_reg   <= 5'h00;
         id_shift_reg <= 14'h0000;
      end
      else if (ce_i)
      begin
         // A rejected code leaves no stale bits for the next attempt
         if (state_reg != S_WAIT | id_done)
         begin
            id_cnt_reg   <= 5'h00;
            id_shift_reg <= 14'h0000;
         end
         else if (id_strobe_i)
         begin
            id_cnt_reg   <= id_cnt_reg + 5'h01;
            id_shift_reg <= {id_shift_reg[12:0], id_bit_i};
         end
      end
   end

   // ==========================================
   // Line and reader outputs
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         off_hook_o  <= 1'b0;
         tx_data_o   <= 1'b1;
         reader_on_o <= 1'b0;
      end
      else if (ce_i)
      begin
         off_hook_o  <= (state_next != S_IDLE);
         // Reader runs only after valid code and while carrier holds
         reader_on_o <= send_go;
         // Line idles at mark so a stopped reader sends nothing
         tx_data_o   <= send_go ? tape_i : 1'b1;
      end
   end

   // ==========================================
   // Break alarm
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         break_lamp_o <= 1'b0;
         bell_o       <= 1'b0;
      end
      else if (ce_i)
      begin
         // Alarm latches until software clears it; a new break wins
         if (brk_enter)
         begin
            break_lamp_o <= 1'b1;
            bell_o       <= 1'b1;
         end
         else if (lamp_clr)
         begin
            break_lamp_o <= 1'b0;
            bell_o       <= 1'b0;
         end
      end
   end

endmodule

// ===== design/usbc_defines.vh
`ifndef USBC_DEFINES_VH
`define USBC_DEFINES_VH
// ==========================================
// Register byte offsets
`define USBC_CTRL_OFS      4'h0
`define USBC_STAT_OFS      4'h4
`define USBC_IRQ_OFS       4'h8
`define USBC_MASK_OFS      4'hc
// ==========================================
// Control fields
`define USBC_CTRL_ENABLE   0
`define USBC_CTRL_OPERATE  1
`define USBC_CTRL_ANSWER   2
`define USBC_CTRL_LAMPCLR  3
// ==========================================
// Event bits
`define USBC_EV_ID_OK      0
`define USBC_EV_ID_BAD     1
`define USBC_EV_BREAK      2
`define USBC_EV_HANGUP     3
`define USBC_EV_CARR_LOST  4
`define USBC_EV_W          5
// ==========================================
// Timing
// Sized wide so the thirty-second span does not wrap in 32 bits
`define USBC_CLK_HZ        64'h000000000ee6b280
`define USBC_CARR_SEC      64'h000000000000001e
`define USBC_CARR_CYC      (`USBC_CLK_HZ * `USBC_CARR_SEC)
`define USBC_ID_BITS       14
`define USBC_ID_CODE       14'h1555
`endif

// ===== verif/usbc_chk.sv
`timescale 1ns/100ps
// ======
// Checker
module usbc_chk
#(
   parameter [63:0] CARR_CYC = 64'd50,
   parameter [13:0] ID_CODE  = 14'h1555
)
(
   // Bus and line
   input wire        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
   input wire [3:0]  wb_adr_i, wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire        carrier_i, id_bit_i, id_strobe_i, off_hook_o,
   input wire        tx_data_o, reader_on_o, break_lamp_o, bell_o
);
   reg [63:0] gap;
   reg [13:0] shr;
   reg [3:0]  cnt;
   reg        ok;
   reg        op;
   wire [13:0] nxt = {shr[12:0], id_bit_i};
   // Gap counts only while off hook, so a fresh call starts from zero
   always @(posedge clk_i)
   begin
      gap <= (rst_i || carrier_i || !off_hook_o) ? 64'h0 : gap + 64'h1;
      if (id_strobe_i)
         shr <= nxt;
      if (rst_i || !off_hook_o)
         cnt <= 4'h0;
      else if (id_strobe_i)
         cnt <= (cnt == 4'hd) ? 4'h0 : cnt + 4'h1;
      if (rst_i || !off_hook_o)
         ok <= 1'b0;
      else if (id_strobe_i && cnt == 4'hd && nxt == ID_CODE)
         ok <= 1'b1;
      if (rst_i)
         op <= 1'b0;
      else if (wb_ack_o && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0])
         op <= wb_dat_i[1];
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
   property p_ack; s_req |=> s_pulse; endproperty
   property p_src; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
   property p_hang; gap > CARR_CYC + 2 |-> !off_hook_o; endproperty
   property p_keep; $fell(off_hook_o) |-> gap + 3 >= CARR_CYC; endproperty
   property p_id; $rose(reader_on_o) |-> ok; endproperty
   property p_tx; !tx_data_o |-> ok; endproperty
   property p_brk; $rose(break_lamp_o) |-> bell_o && !reader_on_o; endproperty
   property p_op; $rose(break_lamp_o) |-> op; endproperty
   property p_cut; !carrier_i |-> ##[0:2] !reader_on_o; endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle");
   a_src: assert property (p_src) else $error("ack without request");
   a_hang: assert property (p_hang) else $error("no hang up");
   a_keep: assert property (p_keep) else $error("early hang up");
   a_id: assert property (p_id) else $error("reader without id");
   a_tx: assert property (p_tx) else $error("data before id");
   a_brk: assert property (p_brk) else $error("break alarm wrong");
   a_op: assert property (p_op) else $error("break in test");
   a_cut: assert property (p_cut) else $error("sends w/o carrier");
endmodule
bind usbc_sender_ctrl usbc_chk #(.CARR_CYC(CARR_CYC), .ID_CODE(ID_CODE))
   u_chk (.*);

// ===== verif/usbc_far.sv
`timescale 1ns/100ps
// ======
// Data set and remote receiver
module usbc_far
(
   input  wire clk_i,
   output reg  ring_o, carrier_o, rev_chan_o, id_bit_o, id_strobe_o
);
   reg busy = 1'b0;
   initial {ring_o, carrier_o, rev_chan_o, id_bit_o, id_strobe_o} = 5'h0;
   // Idle id line toggles so a stale level never looks like data
   always @(posedge clk_i)
      if (!busy)
         id_bit_o <= ~id_bit_o;
   // Slow start-stop character, MSB first, one strobe a bit
   task send_id(input [13:0] code);
      integer i;
      begin
         busy = 1'b1;
         for (i = 13; i >= 0; i = i - 1)
         begin
            @(posedge clk_i);
            id_bit_o <= code[i];
            id_strobe_o <= 1'b1;
            @(posedge clk_i);
            id_strobe_o <= 1'b0;
            id_bit_o <= ~code[i];
            repeat (2) @(posedge clk_i);
         end
         busy = 1'b0;
      end
   endtask
endmodule

// ===== verif/usbc_sender_ctrl_tb_top.sv
`timescale 1ns/100ps
`include "usbc_defines.vh"
// ======
// Bench
module usbc_sender_ctrl_tb_top;
   reg         clk_i, rst_i, cyc, we, tape;
   reg  [3:0]  adr, sel;
   reg  [31:0] dat, q;
   wire [31:0] rdat;
   wire        ack, ring, car, rev, idb, ids, hook, txd, rdr, lamp, bell, irq;
   integer     n_fail = 0;
   integer     checked = 0;
   localparam [13:0] ID = `USBC_ID_CODE;
   usbc_far u_far (.clk_i(clk_i), .ring_o(ring), .carrier_o(car),
      .rev_chan_o(rev), .id_bit_o(idb), .id_strobe_o(ids));
   usbc_sender_ctrl #(.CARR_CYC(64'd50)) u_dut (.clk_i(clk_i),
      .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .ring_i(ring), .carrier_i(car),
      .rev_chan_i(rev), .id_bit_i(idb), .id_strobe_i(ids),
      .off_hook_o(hook), .tape_i(tape), .tx_data_o(txd),
      .reader_on_o(rdr), .break_lamp_o(lamp), .bell_o(bell), .irq_o(irq));
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         checked = checked + 1;
         if (g !== e)
         begin
            $display("mismatch %s exp %h got %h", nm, e, g);
            n_fail = n_fail + 1;
         end
      end
   endtask
   task wb(input [3:0] a, input w, input [3:0] s, input [31:0] d);
      begin
         @(posedge clk_i);
         cyc <= 1'b1;
         we <= w;
         adr <= a;
         sel <= s;
         dat <= d;
         @(posedge clk_i);
         while (ack !== 1'b1) @(posedge clk_i);
         q = rdat;
         cyc <= 1'b0;
         @(posedge clk_i);
      end
   endtask
   task rd(input string nm, input [3:0] a, input [31:0] e);
      begin
         wb(a, 1'b0, 4'hf, 32'h0);
         chk(nm, e, q);
      end
   endtask
   task pause(input integer n);
      repeat (n) @(posedge clk_i);
   endtask
   task dial;
      begin
         u_far.ring_o <= 1'b1;
         pause(4);
         u_far.ring_o <= 1'b0;
         u_far.carrier_o <= 1'b1;
         chk("hook", 1, hook);
      end
   endtask
   task stop_test;
      begin
         $display("checked %0d n_fail %0d", checked, n_fail);
         if (n_fail == 0 && checked > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial
   begin
      #20000;
      n_fail = n_fail + 1;
      stop_test;
   end
   initial
   begin
      {rst_i, tape, cyc, we, adr, sel, dat} = 44'hc00_0000_0000;
      pause(3);
      rst_i <= 1'b0;
      rd("stat", 4'h4, 32'h10);
      rd("mask", 4'hc, 32'h0);
      wb(4'h0, 1'b1, 4'he, 32'h7);
      rd("ctrl", 4'h0, 32'h0);
      wb(4'h0, 1'b1, 4'hf, 32'h7);
      rd("ctrl", 4'h0, 32'h7);
      rd("unmap", 4'h2, 32'h0);
      dial;
      u_far.send_id(ID ^ 14'h1);
      pause(3);
      chk("bad", 2'b01, {rdr, txd});
      chk("irq", 0, irq);
      rd("irq", 4'h8, 32'h2);
      wb(4'hc, 1'b1, 4'hf, 32'h1f);
      chk("irq", 1, irq);
      wb(4'h8, 1'b1, 4'hf, 32'h2);
      chk("irq", 0, irq);
      u_far.send_id(ID);
      pause(3);
      rd("stat", 4'h4, 32'h47);
      tape <= 1'b0;
      pause(2);
      chk("txd", 0, txd);
      u_far.carrier_o <= 1'b0;
      pause(20);
      chk("rdr", 0, rdr);
      chk("txd", 1, txd);
      rd("irq", 4'h8, 32'h11);
      u_far.carrier_o <= 1'b1;
      wb(4'h8, 1'b1, 4'hf, 32'h1f);
      u_far.carrier_o <= 1'b0;
      pause(30);
      chk("hook", 1, hook);
      pause(30);
      chk("hook", 0, hook);
      rd("irq", 4'h8, 32'h18);
      wb(4'h0, 1'b1, 4'hf, 32'h5);
      dial;
      u_far.send_id(ID);
      u_far.rev_chan_o <= 1'b1;
      pause(4);
      chk("test", 3'b001, {lamp, bell, rdr});
      wb(4'h0, 1'b1, 4'hf, 32'h7);
      pause(2);
      chk("brk", 3'b110, {lamp, bell, rdr});
      u_far.rev_chan_o <= 1'b0;
      wb(4'h0, 1'b1, 4'hf, 32'hf);
      chk("clr", 0, {lamp, bell});
      stop_test;
   end
endmodule
